// [inc/qwp_consts.svh]
// qwp_consts.svh: offsets, field positions, codes and timing counts
// assumes: included by bare name wherever these values are needed
`ifndef QWP_CONSTS_SVH
`define QWP_CONSTS_SVH
`define QWP_REVERSIBLE_QUADRANT_PROTECT_TYPE 4'h6
`define QWP_MEM_TYPE 4'hA
`define QWP_CLEAR_BYTE 8'h66
`define QWP_ID_Q0 3'h1
`define QWP_ID_Q1 3'h4
`define QWP_ID_Q2 3'h5
`define QWP_ID_Q3 3'h0
// write cycle length in ref_clk cycles: a plain default, set per part
`define QWP_TWR_CYC 32'h00010000
`define QWP_QUARTER_CYC 25
`define QWP_REG_CMD 8'h00
`define QWP_REG_STATUS 8'h04
`define QWP_CMD_OP_LSB 0
`define QWP_CMD_QUAD_LSB 2
`define QWP_CMD_NOHV_BIT 4
`define QWP_CMD_ADDR_LSB 8
`define QWP_CMD_DATA_LSB 16
`define QWP_CMD_GO_BIT 31
`define QWP_ST_BUSY_BIT 0
`define QWP_ST_ACK_LSB 1
`endif

// [inc/qwp_link_if.sv]
// qwp_link_if: two-wire link plus the address pins between the ends
// assumes: sda is open drain with a pull-up, resolved here
`timescale 1ns/10ps
`default_nettype none
interface qwp_link_if;
    logic scl;
    logic hostSdaOut;
    logic hostSdaOe;
    logic devSdaOut;
    logic devSdaOe;
    logic sda;
    logic hvLevel;
    logic addrPinOne;
    logic addrPinTwo;

    // wired-and with pull-up
    assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

    modport host (output scl, hostSdaOut, hostSdaOe, hvLevel, addrPinOne,
        addrPinTwo, input sda);
    modport dev (input scl, sda, hvLevel, addrPinOne, addrPinTwo,
        output devSdaOut, devSdaOe);
endinterface : qwp_link_if
`default_nettype wire

// [inc/qwp_pkg.sv]
// qwp_pkg: command type and quadrant id coding shared by both ends
// assumes: qwp_consts.svh on the include path
`include "qwp_consts.svh"
package qwp_pkg;
    typedef enum logic [1:0] {QWP_OP_SET, QWP_OP_CLEAR, QWP_OP_QUERY,
        QWP_OP_WRITE} qwp_op_e;
    typedef logic [3:0] qwp_flags_t;

    function automatic logic [2:0] qwp_quad_to_id(input logic [1:0] q);
        case (q)
            2'h0: qwp_quad_to_id = `QWP_ID_Q0;
            2'h1: qwp_quad_to_id = `QWP_ID_Q1;
            2'h2: qwp_quad_to_id = `QWP_ID_Q2;
            default: qwp_quad_to_id = `QWP_ID_Q3;
        endcase
    endfunction : qwp_quad_to_id

    // returns {valid, quadrant index}
    function automatic logic [2:0] qwp_id_to_quad(input logic [2:0] id);
        if (id == `QWP_ID_Q0) qwp_id_to_quad = 3'h4;
        else if (id == `QWP_ID_Q1) qwp_id_to_quad = 3'h5;
        else if (id == `QWP_ID_Q2) qwp_id_to_quad = 3'h6;
        else if (id == `QWP_ID_Q3) qwp_id_to_quad = 3'h7;
        else qwp_id_to_quad = 3'h0;
    endfunction : qwp_id_to_quad
endpackage : qwp_pkg

// [logic/qwp_device.sv]
// qwp_device: quadrant write-protect command decoder and state
// assumes: scl comes from the master and stops outside frames; ref_clk
// free-running; the master leaves at least 8 ref_clk cycles between a
// start and the first scl rise, and between scl edges
//
// Behaviour
// - set command is 0110, id bits, write
// - high voltage held whole set transaction
// - set marks only the named quadrant
// - only clear unprotects, all four together
// - id 001,100,101,000 select quadrants 0..3
// - clear is control byte 66h, acknowledged
// - master sends two don't-care bytes, then stop
// - clear address and data bytes: ack allowed
// - clear ignored without high voltage throughout
// - query is 0110, id bits, read
// - query needs no high voltage
// - query acks control byte only if unprotected
// - query never acks following bytes
// - master ends query with stop
// - address pins one and two ignored
// - write to protected quadrant: data byte nacked
`timescale 1ns/10ps
`default_nettype none
`include "qwp_consts.svh"
module qwp_device #(
    parameter int unsigned TWR_CYCLES = `QWP_TWR_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    qwp_link_if.dev link,
    input wire logic pageHalf,
    output qwp_pkg::qwp_flags_t protFlags,
    output logic writeBusy,
    output logic memWrStb,
    output logic [8:0] memWrAddr,
    output logic [7:0] memWrData
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and start/stop detection on ref_clk
    logic [2:0] pinS;
    logic sclS;
    logic sdaS;
    logic hvS;
    logic prevScl;
    logic prevSda;
    logic startEv;
    logic stopEv;
    logic linkRstN;
    logic inFrame;
    logic hvHeld;

    qwp_sync #(.WIDTH(3)) uPinSync (
        .clk(ref_clk),
        .resetn(resetn),
        .din({link.scl, link.sda, link.hvLevel}),
        .dout(pinS)
    );
    assign sclS = pinS[2];
    assign sdaS = pinS[1];
    assign hvS = pinS[0];
    assign startEv = sclS && prevScl && prevSda && !sdaS;
    assign stopEv = sclS && prevScl && !prevSda && sdaS;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prevScl <= 1'b1;
            prevSda <= 1'b1;
        end else begin
            prevScl <= sclS;
            prevSda <= sdaS;
        end
    end

    // link-side clear: set by a start, lifted once scl is seen low, so
    // the scl domain never needs an edge before the frame's first one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            linkRstN <= 1'b0;
        end else if (startEv) begin
            linkRstN <= 1'b0;
        end else if (!sclS) begin
            linkRstN <= 1'b1;
        end
    end

    // high voltage must stay up from start to stop
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            inFrame <= 1'b0;
            hvHeld <= 1'b0;
        end else if (startEv) begin
            inFrame <= 1'b1;
            hvHeld <= hvS;
        end else begin
            if (stopEv) begin
                inFrame <= 1'b0;
            end
            if (!hvS) begin
                hvHeld <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // scl domain: bit and byte capture
    logic [3:0] bitCnt;
    logic [1:0] byteCnt;
    logic [6:0] shiftReg;
    logic [7:0] ctrlByte;
    logic [7:0] addrByte;
    logic [7:0] dataByte;
    logic [7:0] nextByte;

    assign nextByte = {shiftReg, link.sda};

    always_ff @(posedge link.scl or negedge linkRstN) begin
        if (!linkRstN) begin
            bitCnt <= 4'h0;
            byteCnt <= 2'h0;
            shiftReg <= 7'h00;
            ctrlByte <= 8'h00;
            addrByte <= 8'h00;
            dataByte <= 8'h00;
        end else if (bitCnt == 4'h8) begin
            bitCnt <= 4'h0;
            if (byteCnt != 2'h3) begin
                byteCnt <= byteCnt + 2'h1;
            end
        end else begin
            bitCnt <= bitCnt + 4'h1;
            shiftReg <= nextByte[6:0];
            if (bitCnt == 4'h7) begin
                if (byteCnt == 2'h0) begin
                    ctrlByte <= nextByte;
                end else if (byteCnt == 2'h1) begin
                    addrByte <= nextByte;
                end else begin
                    dataByte <= nextByte; // page writes keep the last
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command decode, shared by the acknowledge and the stop action
    // only the control byte, plus addrByte bit 7 and pageHalf for memory writes, is looked at, never the address pins
    logic [2:0] quadInfo;
    logic quadValid;
    logic [1:0] quadIdx;
    logic prot;
    logic isRswp;
    logic isClear;
    logic isSet;
    logic isQuery;
    logic isMemWr;
    logic memProt;

    assign quadInfo = qwp_pkg::qwp_id_to_quad(ctrlByte[3:1]);
    assign quadValid = quadInfo[2];
    assign quadIdx = quadInfo[1:0];
    assign prot = protFlags[quadIdx];
    assign isRswp = ctrlByte[7:4] == `QWP_REVERSIBLE_QUADRANT_PROTECT_TYPE;
    assign isClear = ctrlByte == `QWP_CLEAR_BYTE;
    assign isSet = isRswp && quadValid && !ctrlByte[0] && !isClear;
    assign isQuery = isRswp && quadValid && ctrlByte[0];
    assign isMemWr = ctrlByte[7:4] == `QWP_MEM_TYPE && !ctrlByte[0];
    assign memProt = protFlags[{pageHalf, addrByte[7]}];

    logic ackWanted;

    // flags and hvS are levels that only move outside a frame or while
    // busy, when every byte is refused anyway
    always_comb begin
        ackWanted = 1'b0;
        if (!writeBusy) begin
            if (byteCnt == 2'h0) begin
                ackWanted = (isSet && hvS && !prot)
                    || (isClear && hvS)
                    || (isQuery && !prot)
                    || isMemWr;
            end else begin
                // query bytes fall through to a refusal
                ackWanted = (isSet && hvS && !prot)
                    || (isClear && hvS)
                    || (isMemWr && (byteCnt == 2'h1 || !memProt));
            end
        end
    end

    // acknowledge driven on the falling edge after bit 8, released on
    // the falling edge after the ninth clock
    always_ff @(negedge link.scl or negedge linkRstN) begin
        if (!linkRstN) begin
            link.devSdaOe <= 1'b0;
        end else begin
            link.devSdaOe <= (bitCnt == 4'h8) && ackWanted;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stop action and self-timed write cycle
    logic cmdOk;
    logic doSet;
    logic doClear;
    logic doMem;
    logic [31:0] twrCnt;
    qwp_pkg::qwp_flags_t pendFlags;

    // capture registers are still: scl does not move after a stop; the
    // stop's own scl rise follows the last ack, hence one counted bit
    assign cmdOk = inFrame && !writeBusy && bitCnt == 4'h1
        && byteCnt == 2'h3;
    assign doSet = cmdOk && isSet && hvHeld && !prot;
    assign doClear = cmdOk && isClear && hvHeld;
    assign doMem = cmdOk && isMemWr && !memProt;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            link.devSdaOut <= 1'b0;
            protFlags <= 4'h0;
            pendFlags <= 4'h0;
            writeBusy <= 1'b0;
            twrCnt <= 32'h0;
        end else if (writeBusy) begin
            twrCnt <= twrCnt + 32'h1;
            if (twrCnt == TWR_CYCLES - 32'h1) begin
                writeBusy <= 1'b0;
                protFlags <= pendFlags;
            end
        end else if (stopEv && (doSet || doClear || doMem)) begin
            writeBusy <= 1'b1;
            twrCnt <= 32'h0;
            if (doClear) begin
                pendFlags <= 4'h0;
            end else if (doSet) begin
                pendFlags <= protFlags | (4'h1 << quadIdx);
            end else begin
                pendFlags <= protFlags;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            memWrStb <= 1'b0;
            memWrAddr <= 9'h000;
            memWrData <= 8'h00;
        end else begin
            memWrStb <= stopEv && doMem && !writeBusy;
            if (stopEv && doMem) begin
                memWrAddr <= {pageHalf, addrByte};
                memWrData <= dataByte;
            end
        end
    end
endmodule : qwp_device
`default_nettype wire

// [logic/qwp_host.sv]
// qwp_host: two-wire master for protect commands, ordered over APB
// assumes: APB on ref_clk; the link clock is made here by a divider
`timescale 1ns/10ps
`default_nettype none
`include "qwp_consts.svh"
module qwp_host #(
    parameter int unsigned QUARTER_CYC = `QWP_QUARTER_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    qwp_link_if.host link
);
    typedef enum logic [1:0] {QWP_HS_IDLE, QWP_HS_START, QWP_HS_BIT,
        QWP_HS_STOP} qwp_hstate_e;

    qwp_hstate_e state;
    logic [31:0] cmdReg;
    logic busy;
    logic [2:0] ackLog;
    logic [26:0] txBits;
    logic [15:0] qCnt;
    logic [1:0] phase;
    logic [3:0] bitPos;
    logic [1:0] byteNo;
    logic sdaS;
    logic tick;
    logic goReq;
    qwp_pkg::qwp_op_e op;
    logic [2:0] quadId;
    logic [7:0] ctrl;

    qwp_sync #(.WIDTH(1)) uSdaSync (
        .clk(ref_clk),
        .resetn(resetn),
        .din(link.sda),
        .dout(sdaS)
    );

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then pready
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                if (paddr == `QWP_REG_CMD) begin
                    prdata <= cmdReg;
                end else if (paddr == `QWP_REG_STATUS) begin
                    prdata <= {28'h0, ackLog, busy};
                end else begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // commands written while a frame runs are dropped
    assign goReq = psel && penable && pready && pwrite && !busy
        && paddr == `QWP_REG_CMD && pwdata[`QWP_CMD_GO_BIT];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmdReg <= 32'h0;
        end else if (psel && penable && pready && pwrite && !busy
                && paddr == `QWP_REG_CMD) begin
            cmdReg <= {1'b0, pwdata[30:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame engine: start, three bytes with acknowledge, stop
    assign op = qwp_pkg::qwp_op_e'(pwdata[`QWP_CMD_OP_LSB +: 2]);
    assign quadId = qwp_pkg::qwp_quad_to_id(pwdata[`QWP_CMD_QUAD_LSB +: 2]);
    assign tick = qCnt == QUARTER_CYC[15:0] - 16'h1;

    always_comb begin
        case (op)
            qwp_pkg::QWP_OP_SET: ctrl = {`QWP_REVERSIBLE_QUADRANT_PROTECT_TYPE, quadId, 1'b0};
            qwp_pkg::QWP_OP_CLEAR: ctrl = `QWP_CLEAR_BYTE;
            qwp_pkg::QWP_OP_QUERY: begin
                ctrl = {`QWP_REVERSIBLE_QUADRANT_PROTECT_TYPE, quadId, 1'b1};
            end
            default: ctrl = {`QWP_MEM_TYPE, 4'h0};
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= QWP_HS_IDLE;
            busy <= 1'b0;
            ackLog <= 3'h0;
            txBits <= 27'h0;
            qCnt <= 16'h0;
            phase <= 2'h0;
            bitPos <= 4'h0;
            byteNo <= 2'h0;
            link.scl <= 1'b1;
            link.hostSdaOe <= 1'b0;
            link.hostSdaOut <= 1'b0;
            link.hvLevel <= 1'b0;
            link.addrPinOne <= 1'b0; // tied low
            link.addrPinTwo <= 1'b0;
        end else if (state == QWP_HS_IDLE) begin
            if (goReq) begin
                busy <= 1'b1;
                ackLog <= 3'h0;
                // the two trailing bytes are don't-care for protect commands
                txBits <= {ctrl, 1'b1, pwdata[`QWP_CMD_ADDR_LSB +: 8], 1'b1,
                    pwdata[`QWP_CMD_DATA_LSB +: 8], 1'b1};
                // withholding the high voltage makes a refused command
                link.hvLevel <= (op == qwp_pkg::QWP_OP_SET
                    || op == qwp_pkg::QWP_OP_CLEAR)
                    && !pwdata[`QWP_CMD_NOHV_BIT];
                qCnt <= 16'h0;
                phase <= 2'h0;
                state <= QWP_HS_START;
            end
        end else begin
            qCnt <= tick ? 16'h0 : qCnt + 16'h1;
            if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    QWP_HS_START: begin
                        if (phase == 2'h1) link.hostSdaOe <= 1'b1;
                        if (phase == 2'h2) link.scl <= 1'b0;
                        if (phase == 2'h3) begin
                            bitPos <= 4'h0;
                            byteNo <= 2'h0;
                            state <= QWP_HS_BIT;
                        end
                    end
                    QWP_HS_BIT: begin
                        if (phase == 2'h0) link.hostSdaOe <= !txBits[26];
                        if (phase == 2'h1) link.scl <= 1'b1;
                        if (phase == 2'h2 && bitPos == 4'h8) begin
                            ackLog <= {ackLog[1:0], !sdaS};
                        end
                        if (phase == 2'h3) begin
                            link.scl <= 1'b0;
                            txBits <= {txBits[25:0], 1'b0};
                            bitPos <= bitPos == 4'h8 ? 4'h0 : bitPos + 4'h1;
                            if (bitPos == 4'h8) begin
                                byteNo <= byteNo + 2'h1;
                                if (byteNo == 2'h2) state <= QWP_HS_STOP;
                            end
                        end
                    end
                    default: begin
                        // stop ends every frame, queries included
                        if (phase == 2'h0) link.hostSdaOe <= 1'b1;
                        if (phase == 2'h1) link.scl <= 1'b1;
                        if (phase == 2'h2) link.hostSdaOe <= 1'b0;
                        if (phase == 2'h3) begin
                            link.hvLevel <= 1'b0;
                            busy <= 1'b0;
                            state <= QWP_HS_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule : qwp_host
`default_nettype wire

// [logic/qwp_sync.sv]
// qwp_sync: two-flop synchroniser for levels
// assumes: inputs are levels slower than the destination clock
`timescale 1ns/10ps
`default_nettype none
module qwp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage <= '0;
            dout <= '0;
        end else begin
            stage <= din;
            dout <= stage;
        end
    end
endmodule : qwp_sync
`default_nettype wire

// [test/qwp_link_assertions.sv]
// qwp_link_assertions: link answers and protection flag checks
// assumes: instantiated beside the link interface, all on ref_clk
`timescale 1ns/10ps
`default_nettype none
module qwp_link_assertions #(
    parameter int unsigned TWR_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic devSdaOe,
    input wire logic hvLevel,
    input wire qwp_pkg::qwp_flags_t protFlags,
    input wire logic writeBusy
);
    logic sclQ;
    logic sdaQ;
    logic rise;
    logic idOk;
    logic [4:0] bitCnt;
    logic [7:0] ctrl;
    logic [1:0] quad;
    int unsigned busyCnt;
    assign rise = scl && !sclQ;
    assign idOk = ctrl[3:1] inside {3'h0, 3'h1, 3'h4, 3'h5};
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end else begin
            sclQ <= scl;
            sdaQ <= sda;
        end
    end
    // count clocks since start; idle value keeps checks quiet before one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bitCnt <= 5'h1F;
            ctrl <= 8'h00;
        end else if (scl && sclQ && sdaQ && !sda) begin
            bitCnt <= 5'h00;
        end else if (rise && bitCnt != 5'h1F) begin
            bitCnt <= bitCnt + 5'h01;
            if (bitCnt < 5'h08) ctrl <= {ctrl[6:0], sda};
        end
    end
    always_comb begin
        case (ctrl[3:1])
            3'h1: quad = 2'h0;
            3'h4: quad = 2'h1;
            3'h5: quad = 2'h2;
            default: quad = 2'h3;
        endcase
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) busyCnt <= 0;
        else if (writeBusy) busyCnt <= busyCnt + 1;
        else busyCnt <= 0;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_flags_after_cycle:
        assert property ($changed(protFlags) |->
            $past(writeBusy) || $past(writeBusy, 2))
        else $error("flags changed outside a write cycle");
    a_clear_all_bits:
        assert property (|($past(protFlags) & ~protFlags) |->
            protFlags == 4'h0)
        else $error("flags cleared partly");
    a_single_set:
        assert property ($countones(protFlags & ~$past(protFlags)) <= 1)
        else $error("two flags set at once");
    a_ack_scl_low:
        assert property ($changed(devSdaOe) |-> !scl)
        else $error("device data moved while clock high");
    a_query_answer:
        assert property (rise && bitCnt == 5'h08 && ctrl[7:4] == 4'h6 &&
            ctrl[0] && idOk && !writeBusy |-> sda == protFlags[quad])
        else $error("query answer wrong");
    a_query_tail_nack:
        assert property (rise && (bitCnt == 5'h11 || bitCnt == 5'h1A) &&
            ctrl[7:4] == 4'h6 && ctrl[0] |-> sda)
        else $error("query trailing byte acked");
    a_nohv_refused:
        assert property (rise && bitCnt == 5'h08 && ctrl[7:4] == 4'h6 &&
            !ctrl[0] && !hvLevel |-> sda)
        else $error("set or clear acked without high voltage");
    a_clear_acked:
        assert property (rise && bitCnt == 5'h08 && ctrl == 8'h66 &&
            hvLevel && !writeBusy |-> !sda)
        else $error("clear not acked");
    a_busy_length:
        assert property ($fell(writeBusy) |-> busyCnt >= TWR_CYCLES - 1 &&
            busyCnt <= TWR_CYCLES + 1)
        else $error("write cycle length wrong");
endmodule : qwp_link_assertions
`default_nettype wire

// [test/testbench.sv]
// testbench: host and device joined by the link, host ordered over APB
// assumes: package, interface, design and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "qwp_consts.svh"
module testbench;
    localparam int unsigned TWR = 50;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pageHalf = 1'b0;
    logic noHv = 1'b0;
    qwp_pkg::qwp_flags_t protFlags;
    qwp_pkg::qwp_flags_t model = 4'h0;
    logic writeBusy;
    logic memWrStb;
    logic [8:0] memWrAddr;
    logic [7:0] memWrData;
    int nErrors = 0;
    int nTests = 0;
    int seed = 38;
    logic [32:0] rdQ[$];
    logic [16:0] stbQ[$];
    always #5 ref_clk = !ref_clk;
    qwp_link_if link();
    // short quarter phase and write cycle keep the run small
    qwp_host #(.QUARTER_CYC(10)) qwp_host_inst (.ref_clk, .resetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .link(link));
    qwp_device #(.TWR_CYCLES(TWR)) qwp_device_inst (.ref_clk, .resetn,
        .link(link), .pageHalf, .protFlags, .writeBusy, .memWrStb,
        .memWrAddr, .memWrData);
    qwp_link_assertions #(.TWR_CYCLES(TWR)) qwp_link_assertions_inst (
        .ref_clk, .resetn, .scl(link.scl), .sda(link.sda),
        .devSdaOe(link.devSdaOe), .hvLevel(link.hvLevel), .protFlags,
        .writeBusy);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        if (nErrors == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic give_up;
        nErrors++;
        complete_run();
    endtask : give_up
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [32:0] r);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50) give_up();
    endtask : apb
    // expectation from the flag model, noted before the frame starts
    task automatic cmd(input logic [1:0] op, input logic [1:0] q,
        input logic h, input logic [7:0] a, input logic [7:0] d);
        logic [32:0] r;
        logic [2:0] ack;
        logic p;
        logic c;
        int i;
        pageHalf <= h;
        p = (op == 2'h3) ? model[{h, a[7]}] : model[q];
        c = op == 2'h1 || (op != 2'h2 && !p);
        ack = 3'h7;
        if (op == 2'h0 && p) ack = 3'h0;
        if (op[1] == 1'b0 && noHv) {ack, c} = 4'h0;
        if (op == 2'h2) ack = {!p, 2'h0};
        if (op == 2'h3 && p) ack = 3'h6;
        if (op == 2'h3 && !p) stbQ.push_back({h, a, d});
        apb(1'b1, `QWP_REG_CMD, {1'b1, 7'h0, d, a, 3'h0, noHv, q, op}, r);
        r = 33'h1;
        for (i = 0; i < 1000 && r[0] !== 1'b0; i++)
            apb(1'b0, `QWP_REG_STATUS, 32'h0, r);
        if (i == 1000) give_up();
        rdQ.push_back({29'h0, ack, 1'b0});
        apb(1'b0, `QWP_REG_STATUS, 32'h0, r);
        check("cycle", 33'(writeBusy), 33'(c));
        for (i = 0; i < 200 && writeBusy !== 1'b0; i++)
            @(posedge ref_clk);
        if (i == 200) give_up();
        repeat (3) @(posedge ref_clk);
        if (c && op == 2'h1) model = 4'h0;
        else if (c && op == 2'h0) model[q] = 1'b1;
        check("flags", 33'(protFlags), 33'(model));
    endtask : cmd
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
            check("apb read", {pslverr, prdata}, rdQ.pop_front());
    end
    always @(posedge ref_clk) begin
        if (memWrStb === 1'b1 && stbQ.size() == 0)
            check("stray strobe", 33'h1, 33'h0);
        else if (memWrStb === 1'b1)
            check("write", 33'({memWrAddr, memWrData}),
                33'(stbQ.pop_front()));
    end
    initial begin
        logic [32:0] r;
        int k;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        check("reset flags", 33'(protFlags), 33'h0);
        rdQ.push_back(33'h0);
        apb(1'b0, `QWP_REG_STATUS, 32'h0, r);
        rdQ.push_back({1'b1, 32'h0});
        apb(1'b0, 8'h08, 32'h0, r);
        apb(1'b1, `QWP_REG_CMD, 32'h00ABCD0E, r);
        rdQ.push_back({1'b0, 32'h00ABCD0E});
        apb(1'b0, `QWP_REG_CMD, 32'h0, r);
        for (k = 0; k < 4; k++)
            cmd(2'h2, 2'(k), 1'($random(seed)), 8'($random(seed)), 8'h5A);
        cmd(2'h0, 2'h0, 1'b0, 8'h00, 8'h00);
        cmd(2'h0, 2'h3, 1'b1, 8'hFF, 8'hFF);
        cmd(2'h0, 2'h0, 1'b0, 8'h00, 8'h00);
        // set and clear with the high voltage withheld must be refused
        noHv = 1'b1;
        cmd(2'h0, 2'h1, 1'b0, 8'h00, 8'h00);
        cmd(2'h1, 2'h0, 1'b0, 8'h11, 8'h22);
        noHv = 1'b0;
        for (k = 0; k < 4; k++)
            cmd(2'h2, 2'(k), 1'b0, 8'h00, 8'h00);
        for (k = 0; k < 8; k++)
            cmd(2'h3, 2'h0, 1'($random(seed)), 8'($random(seed)),
                8'($random(seed)));
        cmd(2'h1, 2'h0, 1'b0, 8'($random(seed)), 8'($random(seed)));
        for (k = 0; k < 4; k++)
            cmd(2'h0, 2'(k), 1'b0, 8'h00, 8'h00);
        for (k = 0; k < 4; k++)
            cmd(2'h2, 2'(k), 1'b0, 8'h00, 8'h00);
        cmd(2'h1, 2'h0, 1'b1, 8'h80, 8'h01);
        check("pending writes", 33'(stbQ.size()), 33'h0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
